/* slc_pkg.sv */
package slc_pkg;

  localparam int SLC_ADDR_W = 4;
  localparam int SLC_DATA_W = 32;
  localparam int SLC_PRE_W = 7;

  // word-aligned byte addresses of the register map
  localparam logic [SLC_ADDR_W-1:0] SLC_OFF_CTRL0 = 4'h0;
  localparam logic [SLC_ADDR_W-1:0] SLC_OFF_CTRL1 = 4'h4;
  localparam logic [SLC_ADDR_W-1:0] SLC_OFF_STATUS = 4'h8;

  // latch_control_zero fields
  localparam int SLC_B_PIN_TWO = 7;
  localparam int SLC_B_PIN_ONE = 6;
  localparam int SLC_B_C1_SET = 5;
  localparam int SLC_B_C2_RESET = 4;
  localparam int SLC_B_SOFT_SET = 3;
  localparam int SLC_B_SOFT_RESET = 2;
  localparam int SLC_B_CLK_SET = 0;
  // latch_control_one fields
  localparam int SLC_B_PRE_HI = 7;
  localparam int SLC_B_PRE_LO = 6;
  // status fields
  localparam int SLC_B_ST_LATCH = 0;
  localparam int SLC_B_ST_CMP_ONE = 1;
  localparam int SLC_B_ST_CMP_TWO = 2;

  localparam logic [7:0] SLC_CTRL0_RST = 8'h00;
  localparam logic [7:0] SLC_CTRL1_RST = 8'h00;

  localparam logic [1:0] SLC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SLC_RESP_SLVERR = 2'h2;

  localparam logic [1:0] SLC_PRE_DIV16 = 2'h0;
  localparam logic [1:0] SLC_PRE_DIV32 = 2'h1;
  localparam logic [1:0] SLC_PRE_DIV64 = 2'h2;
  localparam logic [1:0] SLC_PRE_DIV128 = 2'h3;

  typedef struct packed {
    logic two;
    logic one;
  } slc_cmp_t;

  typedef struct packed {
    logic pin_two_source_select;
    logic pin_one_source_select;
    logic cmp_one_set_enable;
    logic cmp_two_reset_enable;
    logic clocked_set_enable;
  } slc_ctrl_t;

  // low-bit mask of the free counter; all ones marks one divided period
  function automatic logic [SLC_PRE_W-1:0] slc_div_mask(
    input logic [1:0] pre
  );
    case (pre)
      SLC_PRE_DIV16: slc_div_mask = 7'h0f;
      SLC_PRE_DIV32: slc_div_mask = 7'h1f;
      SLC_PRE_DIV64: slc_div_mask = 7'h3f;
      SLC_PRE_DIV128: slc_div_mask = 7'h7f;
      default: slc_div_mask = 7'h7f;
    endcase
  endfunction

  function automatic logic slc_is_mapped(
    input logic [SLC_ADDR_W-1:0] addr
  );
    logic [SLC_ADDR_W-1:0] word;
    word = {addr[SLC_ADDR_W-1:2], 2'h0};
    slc_is_mapped = (word == SLC_OFF_CTRL0) || (word == SLC_OFF_CTRL1) ||
                    (word == SLC_OFF_STATUS);
  endfunction

endpackage

/* slc_sync2.sv */
`timescale 1ns/10ps
module slc_sync2 #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import slc_pkg::*;

  logic [W-1:0] meta_reg;

  if (W < 1)
  begin : g_chk
    $error("slc_sync2 width must be at least one");
  end

  // only the second stage is visible outside
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_reg <= '0;
      q <= '0;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // slc_sync2

/* slc_set_clock.sv */
`timescale 1ns/10ps
module slc_set_clock #(
  parameter int CNT_W = slc_pkg::SLC_PRE_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] prescale,
  output logic tick
);
  import slc_pkg::*;

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] mask;
  logic [CNT_W-1:0] gap_reg;
  logic [1:0] prev_pre_reg;
  logic stable_reg;
  logic changed;

  if (CNT_W < SLC_PRE_W)
  begin : g_chk
    $error("slc_set_clock counter too narrow for divide by 128");
  end

  assign mask = CNT_W'(slc_div_mask(prescale));

  // free counter: a prescale change alters the mask at once, not at the next boundary
  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_reg + CNT_W'(1);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      tick <= 1'b0;
    else
      tick <= ((cnt_reg & mask) == mask);
  end

  // helper logic for the spacing check
  assign changed = (prescale != prev_pre_reg);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      gap_reg <= '0;
      prev_pre_reg <= SLC_PRE_DIV16;
      stable_reg <= 1'b0;
    end
    else
    begin
      gap_reg <= tick ? '0 : gap_reg + CNT_W'(1);
      prev_pre_reg <= prescale;
      stable_reg <= (tick ? 1'b1 : stable_reg) && !changed;
    end
  end

  tick_spacing_a: assert property (@(posedge clk) disable iff (rst)
    tick && stable_reg && !changed |-> gap_reg == mask)
    else $error("latch set clock spacing differs from prescale");
endmodule // slc_set_clock

/* slc_top.sv */
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
module slc_top (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic [slc_pkg::SLC_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [slc_pkg::SLC_DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [slc_pkg::SLC_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [slc_pkg::SLC_DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire slc_pkg::slc_cmp_t CMP_RESULT,
  output slc_pkg::slc_cmp_t PIN_OUT,
  output logic LATCH_Q
);
  import slc_pkg::*;

  slc_cmp_t cmp_s;
  slc_ctrl_t ctrl_reg;
  logic [1:0] prescale_reg;
  logic set_pulse_reg;
  logic reset_pulse_reg;
  logic latch_reg;
  slc_cmp_t pin_reg;
  logic set_tick;
  logic set_req;
  logic reset_req;

  logic aw_got_reg;
  logic w_got_reg;
  logic [SLC_ADDR_W-1:0] awaddr_hold_reg;
  logic [7:0] wbyte_hold_reg;
  logic wlane_hold_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [SLC_DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [SLC_ADDR_W-1:0] raddr_reg;

  logic aw_fire;
  logic w_fire;
  logic wr_go;
  logic ar_fire;
  logic [SLC_ADDR_W-1:0] wr_addr;
  logic [SLC_ADDR_W-1:0] wr_word;
  logic [SLC_ADDR_W-1:0] rd_word;
  logic [7:0] wr_byte;
  logic wr_lane;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic [7:0] rd_byte;

  // comparator outputs are asynchronous to the core clock
  slc_sync2 #(
    .W(2)
  ) u_cmp_sync (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .d(CMP_RESULT),
    .q(cmp_s)
  );

  slc_set_clock #(
    .CNT_W(SLC_PRE_W)
  ) u_set_clock (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .prescale(prescale_reg),
    .tick(set_tick)
  );

  // write channel: address and data taken in either order
  assign S_AXI_AWREADY = !aw_got_reg && !bvalid_reg;
  assign S_AXI_WREADY = !w_got_reg && !bvalid_reg;
  assign aw_fire = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_fire = S_AXI_WVALID && S_AXI_WREADY;
  assign wr_go = (aw_got_reg || aw_fire) && (w_got_reg || w_fire);
  assign wr_addr = aw_got_reg ? awaddr_hold_reg : S_AXI_AWADDR;
  assign wr_byte = w_got_reg ? wbyte_hold_reg : S_AXI_WDATA[7:0];
  assign wr_lane = w_got_reg ? wlane_hold_reg : S_AXI_WSTRB[0];
  assign wr_word = {wr_addr[SLC_ADDR_W-1:2], 2'h0};
  // upper byte lanes hold no bits, so only lane 0 matters
  assign wr_ctrl0 = wr_go && wr_lane && (wr_word == SLC_OFF_CTRL0);
  assign wr_ctrl1 = wr_go && wr_lane && (wr_word == SLC_OFF_CTRL1);

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      aw_got_reg <= 1'b0;
      awaddr_hold_reg <= '0;
    end
    else if (wr_go)
      aw_got_reg <= 1'b0;
    else if (aw_fire)
    begin
      aw_got_reg <= 1'b1;
      awaddr_hold_reg <= S_AXI_AWADDR;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      w_got_reg <= 1'b0;
      wbyte_hold_reg <= '0;
      wlane_hold_reg <= 1'b0;
    end
    else if (wr_go)
      w_got_reg <= 1'b0;
    else if (w_fire)
    begin
      w_got_reg <= 1'b1;
      wbyte_hold_reg <= S_AXI_WDATA[7:0];
      wlane_hold_reg <= S_AXI_WSTRB[0];
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= SLC_RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= slc_is_mapped(wr_addr) ? SLC_RESP_OKAY : SLC_RESP_SLVERR;
    end
    else if (S_AXI_BREADY)
      bvalid_reg <= 1'b0;
  end

  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      ctrl_reg <= slc_ctrl_t'(0);
    else if (wr_ctrl0)
    begin
      ctrl_reg.pin_two_source_select <= wr_byte[SLC_B_PIN_TWO];
      ctrl_reg.pin_one_source_select <= wr_byte[SLC_B_PIN_ONE];
      ctrl_reg.cmp_one_set_enable <= wr_byte[SLC_B_C1_SET];
      ctrl_reg.cmp_two_reset_enable <= wr_byte[SLC_B_C2_RESET];
      ctrl_reg.clocked_set_enable <= wr_byte[SLC_B_CLK_SET];
    end
  end

  // pulse bits live for one cycle; writing zero leaves nothing behind
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      set_pulse_reg <= 1'b0;
      reset_pulse_reg <= 1'b0;
    end
    else
    begin
      set_pulse_reg <= wr_ctrl0 && wr_byte[SLC_B_SOFT_SET];
      reset_pulse_reg <= wr_ctrl0 && wr_byte[SLC_B_SOFT_RESET];
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      prescale_reg <= SLC_CTRL1_RST[SLC_B_PRE_HI:SLC_B_PRE_LO];
    else if (wr_ctrl1)
      prescale_reg <= wr_byte[SLC_B_PRE_HI:SLC_B_PRE_LO];
  end

  assign set_req = (cmp_s.one && ctrl_reg.cmp_one_set_enable) ||
                   set_pulse_reg ||
                   (set_tick && ctrl_reg.clocked_set_enable);
  assign reset_req = (cmp_s.two && ctrl_reg.cmp_two_reset_enable) ||
                     reset_pulse_reg;

  // reset dominates when both inputs are active, keeping the latch defined
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      latch_reg <= 1'b0;
    else if (reset_req)
      latch_reg <= 1'b0;
    else if (set_req)
      latch_reg <= 1'b1;
  end

  // pin drive only; output enable and direction belong to the pad logic
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      pin_reg <= slc_cmp_t'(0);
    else
    begin
      pin_reg.one <= ctrl_reg.pin_one_source_select ? latch_reg
                                                    : cmp_s.one;
      pin_reg.two <= ctrl_reg.pin_two_source_select ? !latch_reg
                                                    : cmp_s.two;
    end
  end

  assign PIN_OUT = pin_reg;
  assign LATCH_Q = latch_reg;

  // read channel
  assign S_AXI_ARREADY = !rvalid_reg;
  assign ar_fire = S_AXI_ARVALID && S_AXI_ARREADY;
  assign rd_word = {S_AXI_ARADDR[SLC_ADDR_W-1:2], 2'h0};

  always_comb
  begin
    rd_byte = 8'h00;
    case (rd_word)
      SLC_OFF_CTRL0:
      begin
        rd_byte[SLC_B_PIN_TWO] = ctrl_reg.pin_two_source_select;
        rd_byte[SLC_B_PIN_ONE] = ctrl_reg.pin_one_source_select;
        rd_byte[SLC_B_C1_SET] = ctrl_reg.cmp_one_set_enable;
        rd_byte[SLC_B_C2_RESET] = ctrl_reg.cmp_two_reset_enable;
        rd_byte[SLC_B_CLK_SET] = ctrl_reg.clocked_set_enable;
      end
      SLC_OFF_CTRL1:
        rd_byte[SLC_B_PRE_HI:SLC_B_PRE_LO] = prescale_reg;
      SLC_OFF_STATUS:
      begin
        rd_byte[SLC_B_ST_LATCH] = latch_reg;
        rd_byte[SLC_B_ST_CMP_ONE] = cmp_s.one;
        rd_byte[SLC_B_ST_CMP_TWO] = cmp_s.two;
      end
      default:
        rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= SLC_RESP_OKAY;
      raddr_reg <= '0;
    end
    else if (ar_fire)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h000000, rd_byte};
      rresp_reg <= slc_is_mapped(S_AXI_ARADDR) ? SLC_RESP_OKAY
                                               : SLC_RESP_SLVERR;
      raddr_reg <= rd_word;
    end
    else if (S_AXI_RREADY)
      rvalid_reg <= 1'b0;
  end

  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;

  sequence soft_set_write_s;
    wr_ctrl0 && wr_byte[SLC_B_SOFT_SET];
  endsequence

  sequence set_pulse_once_s;
    set_pulse_reg ##1 !set_pulse_reg;
  endsequence

  pin_one_mux_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    ctrl_reg.pin_one_source_select && $stable(ctrl_reg) |=>
      PIN_OUT.one == $past(latch_reg))
    else $error("pin one does not follow latch");

  pin_two_mux_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !ctrl_reg.pin_two_source_select && $stable(ctrl_reg) |=>
      PIN_OUT.two == $past(cmp_s.two))
    else $error("pin two does not follow comparator two");

  soft_set_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    soft_set_write_s |=> set_pulse_once_s)
    else $error("soft set pulse not a single cycle");

  soft_set_latch_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    soft_set_write_s ##1 !reset_req |=> latch_reg)
    else $error("soft set pulse did not set latch");

  status_true_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    ar_fire && rd_word == SLC_OFF_STATUS |=>
      S_AXI_RDATA[SLC_B_ST_CMP_TWO:SLC_B_ST_CMP_ONE] == $past(cmp_s))
    else $error("status does not show comparator result");

  ctrl1_zero_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    S_AXI_RVALID && raddr_reg == SLC_OFF_CTRL1 |->
      S_AXI_RDATA[SLC_B_PRE_LO-1:0] == '0)
    else $error("unimplemented control one bits not zero");

  ctrl0_zero_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    S_AXI_RVALID && raddr_reg == SLC_OFF_CTRL0 |->
      S_AXI_RDATA[SLC_B_SOFT_SET:SLC_B_CLK_SET+1] == '0)
    else $error("pulse or unused control zero bits read nonzero");

  cmp_reset_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    cmp_s.two && ctrl_reg.cmp_two_reset_enable |=> !latch_reg)
    else $error("comparator two did not reset latch");

  cmp_set_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    cmp_s.one && ctrl_reg.cmp_one_set_enable && !reset_req |=> latch_reg)
    else $error("comparator one did not set latch");
endmodule // slc_top

/* slc_cmp_model.sv */
`timescale 1ns/10ps
module slc_cmp_model
  import slc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire slc_pkg::slc_cmp_t level,
  output slc_pkg::slc_cmp_t cmp
);
  // outputs move on the rising edge, the same edge at which the block samples them
  // pin enables and directions stay on this side and are taken as set
  always_ff @(posedge clk)
  begin
    cmp <= rst ? '0 : level;
  end
endmodule // slc_cmp_model

/* tb_sr_latch_control.sv */
`timescale 1ns/10ps
module tb_sr_latch_control;
  import slc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] awa = '0;
  logic [3:0] ara = '0;
  logic [3:0] ws = 4'hf;
  logic [31:0] wd = '0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bri = 1'b0;
  logic arv = 1'b0;
  logic rri = 1'b0;
  logic awr, wr_rdy, bv, arr, rv, lq;
  logic [1:0] br, rr;
  logic [31:0] rd_d;
  slc_cmp_t lvl = '0;
  slc_cmp_t cmp, pin;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int t1;
  int p;
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  slc_top u_dut (.CORE_CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awa),
    .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr_rdy), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bri), .S_AXI_ARADDR(ara), .S_AXI_ARPROT(3'h0),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd_d),
    .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rri),
    .CMP_RESULT(cmp), .PIN_OUT(pin), .LATCH_Q(lq));
  slc_cmp_model u_cmp (.clk(clk), .rst(rst), .level(lvl), .cmp(cmp));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hung();
    fail_count++;
    $display("BAD %0t wait ran out", $time);
    tally_and_finish();
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    int n;
    @(posedge clk);
    awa <= a;
    wd <= {24'h0, d};
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bri <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk);
      if (awv && awr)
        awv <= 1'b0;
      if (wv && wr_rdy)
        wv <= 1'b0;
      if (bv && bri)
      begin
        chk({30'h0, br}, {30'h0, er});
        bri <= 1'b0;
        break;
      end
    end
    if (n == 40)
      hung();
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    int n;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rri <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk);
      if (arv && arr)
        arv <= 1'b0;
      if (rv && rri)
      begin
        chk(rd_d, ed);
        chk({30'h0, rr}, {30'h0, er});
        rri <= 1'b0;
        break;
      end
    end
    if (n == 40)
      hung();
  endtask

  task automatic ticks(input int k);
    repeat (k) @(posedge clk);
  endtask

  // polls the latch; the cycle of the edge that shows it is kept in cyc
  task automatic wait_q(input logic v);
    int n;
    for (n = 0; n < 300; n++)
    begin
      @(posedge clk);
      if (lq === v)
        break;
    end
    if (n == 300)
      hung();
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(SLC_OFF_CTRL0, 32'h0, SLC_RESP_OKAY);
    rd(SLC_OFF_CTRL1, 32'h0, SLC_RESP_OKAY);
    wr(SLC_OFF_CTRL1, 8'hff, 4'hf, SLC_RESP_OKAY);
    rd(SLC_OFF_CTRL1, 32'hc0, SLC_RESP_OKAY);
    wr(SLC_OFF_CTRL1, 8'h00, 4'h0, SLC_RESP_OKAY);
    rd(SLC_OFF_CTRL1, 32'hc0, SLC_RESP_OKAY);
    wr(SLC_OFF_CTRL0, 8'hf3, 4'hf, SLC_RESP_OKAY);
    rd(SLC_OFF_CTRL0, 32'hf1, SLC_RESP_OKAY);
    wr(SLC_OFF_CTRL0, 8'h04, 4'hf, SLC_RESP_OKAY);
    ticks(3);
    chk({31'h0, lq}, 32'h0);
    rd(SLC_OFF_CTRL0, 32'h0, SLC_RESP_OKAY);
    wr(4'hc, 8'hff, 4'hf, SLC_RESP_SLVERR);
    rd(4'hc, 32'h0, SLC_RESP_SLVERR);
    $display("test registers done");
    lvl <= 2'b01;
    ticks(6);
    chk({30'h0, pin}, 32'h1);
    rd(SLC_OFF_STATUS, 32'h2, SLC_RESP_OKAY);
    wr(SLC_OFF_CTRL0, 8'hc0, 4'hf, SLC_RESP_OKAY);
    ticks(3);
    chk({30'h0, pin}, 32'h2);
    wr(SLC_OFF_CTRL0, 8'hc8, 4'hf, SLC_RESP_OKAY);
    ticks(3);
    chk({31'h0, lq}, 32'h1);
    chk({30'h0, pin}, 32'h1);
    rd(SLC_OFF_CTRL0, 32'hc0, SLC_RESP_OKAY);
    wr(SLC_OFF_CTRL0, 8'hc0, 4'hf, SLC_RESP_OKAY);
    lvl <= 2'b10;
    ticks(6);
    chk({31'h0, lq}, 32'h1);
    chk({30'h0, pin}, 32'h1);
    rd(SLC_OFF_STATUS, 32'h5, SLC_RESP_OKAY);
    $display("test pins done");
    wr(SLC_OFF_CTRL0, 8'h10, 4'hf, SLC_RESP_OKAY);
    ticks(3);
    chk({31'h0, lq}, 32'h0);
    wr(SLC_OFF_CTRL0, 8'h00, 4'hf, SLC_RESP_OKAY);
    lvl <= 2'b01;
    ticks(6);
    chk({31'h0, lq}, 32'h0);
    wr(SLC_OFF_CTRL0, 8'h20, 4'hf, SLC_RESP_OKAY);
    ticks(3);
    chk({31'h0, lq}, 32'h1);
    lvl <= 2'b00;
    $display("test comparator drive done");
    // two set edges a period apart; the reset pulse lands well inside it
    for (p = 0; p < 4; p++)
    begin
      wr(SLC_OFF_CTRL0, 8'h04, 4'hf, SLC_RESP_OKAY);
      wr(SLC_OFF_CTRL1, {p[1:0], 6'h0}, 4'hf, SLC_RESP_OKAY);
      ticks(130);
      wr(SLC_OFF_CTRL0, 8'h01, 4'hf, SLC_RESP_OKAY);
      wait_q(1'b1);
      t1 = cyc;
      wr(SLC_OFF_CTRL0, 8'h05, 4'hf, SLC_RESP_OKAY);
      wait_q(1'b0);
      wait_q(1'b1);
      chk(32'(cyc - t1), 32'(16 << p));
    end
    $display("test prescale done");
    tally_and_finish();
  end
endmodule // tb_sr_latch_control
